// ==== hdl/pcd_bank_if.sv ====
`timescale 1ns/10ps
interface pcd_bank_if;
  import pcd_pkg::*;
  logic wr_en;
  logic [PCD_SLOT_W-1:0] wr_idx;
  logic [PCD_VAL_W-1:0] wr_data;
  logic [PCD_SLOT_W-1:0] rd_idx;
  logic [PCD_VAL_W-1:0] rd_data;
  modport writer (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ==== hdl/pcd_param_bank.sv ====
`timescale 1ns/10ps
module pcd_param_bank import pcd_pkg::*; #(
  parameter int unsigned SLOTS = PCD_NUM_SLOTS
) (
  input wire logic clk,
  input wire logic rst_b,
  pcd_bank_if.bank bus
);
  // Index width is fixed by the interface, so the slot count must fit in it
  if (SLOTS < 1 || SLOTS > (1 << PCD_SLOT_W)) begin : g_bad_slots
    $error("pcd_param_bank: SLOTS out of range");
  end

  logic [PCD_VAL_W-1:0] mem_r [SLOTS];
  logic [PCD_VAL_W-1:0] mem_nxt [SLOTS];

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (bus.wr_en && bus.wr_idx == PCD_SLOT_W'(g)) mem_nxt[g] = bus.wr_data;
      end
      always_ff @(posedge clk) begin
        if (!rst_b) mem_r[g] <= '0;
        else mem_r[g] <= mem_nxt[g];
      end
    end
  endgenerate

  // Unpopulated indices read as zero
  always_comb begin
    bus.rd_data = '0;
    if (32'(bus.rd_idx) < SLOTS) bus.rd_data = mem_r[bus.rd_idx];
  end
endmodule

// ==== hdl/pcd_payload_command_decoder.sv ====
// What this block does
// R01 - Bits 15:14 equal 1 mark payload command
// R02 - Opcode comes from bits 9:0
// R03 - Header plus 32-bit payload consumed together
// R04 - Offsets, strides, lengths are byte counts
// R05 - 0x000-0x003 load input tile offsets
// R06 - 0x004-0x006 load signed input strides
// R07 - 0x010-0x013 load output tile offsets
// R08 - 0x014-0x016 load signed output strides
// R09 - 0x020 coefficient offset, 0x021 32-bit length
// R10 - 0x022 bias offset, 0x023 20-bit length
// R11 - 0x024 output shift; 32-bit drops multiplier
// R12 - 0x025 first multiplier depends on mode
// R13 - 0x026 second multiplier only in mode 0
// R14 - 0x030/0x031 copy source, destination offsets
// R15 - 0x032 copy row or total length
// R16 - 0x033 skip after each row
// R17 - 0x034 skip after each plane
// R18 - Stride mode from region command bits 10:9
// R19 - Row count from parameter-only command
// R20 - Unlisted opcodes change nothing, payload consumed
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module pcd_payload_command_decoder import pcd_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [PCD_WORD_W-1:0] CMD_WORD,
  output logic PAYLOAD_PENDING,
  input wire logic [PCD_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [PCD_WORD_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [PCD_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [PCD_WORD_W-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  pcd_bank_if bank_bus ();

  pcd_param_bank #(.SLOTS(PCD_NUM_SLOTS)) u_bank (
    .clk(CLK),
    .rst_b(RST_B),
    .bus(bank_bus)
  );

  pcd_state_type state_r, state_nxt;
  logic [PCD_OP_W-1:0] op_r, op_nxt;
  logic [PCD_PARAM_W-1:0] param_r, param_nxt;
  logic [1:0] stride_mode_r, stride_mode_nxt;
  logic prec32_r, prec32_nxt;
  logic [PCD_PARAM_W-1:0] rows_r, rows_nxt;
  logic [PCD_CNT_W-1:0] done_cnt_r, done_cnt_nxt;
  logic [PCD_CNT_W-1:0] unknown_cnt_r, unknown_cnt_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [PCD_WORD_W-1:0] rdata_r, rdata_nxt;

  logic accept;
  logic [1:0] word_class;
  logic [PCD_OP_W-1:0] word_op;
  logic [PCD_PARAM_W-1:0] word_param;
  logic [5:0] slot_hit;
  logic [1:0] scale_mode;
  logic wr_hs;
  logic rd_hs;

  assign word_class = CMD_WORD[PCD_CLASS_HI:PCD_CLASS_LO];
  assign word_op = CMD_WORD[PCD_OP_LO +: PCD_OP_W];
  assign word_param = CMD_WORD[PCD_PARAM_LO +: PCD_PARAM_W];
  assign slot_hit = pcd_slot_of(op_r);
  assign scale_mode = ctrl_r[PCD_CTRL_MODE_LO +: 2];
  // Stream stalls while software holds the decoder disabled
  assign CMD_READY = ctrl_r[PCD_CTRL_EN_BIT];
  assign accept = CMD_VALID && CMD_READY;
  assign PAYLOAD_PENDING = (state_r == PCD_ST_PAYLOAD);

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    param_nxt = param_r;
    stride_mode_nxt = stride_mode_r;
    prec32_nxt = prec32_r;
    rows_nxt = rows_r;
    done_cnt_nxt = done_cnt_r;
    unknown_cnt_nxt = unknown_cnt_r;
    bank_bus.wr_en = 1'b0;
    bank_bus.wr_idx = slot_hit[PCD_SLOT_W-1:0];
    // Values are kept as byte quantities, no scaling applied [R04]
    bank_bus.wr_data = {param_r, CMD_WORD};
    case (slot_hit[PCD_SLOT_W-1:0])
      PCD_SLOT_COEF_LENGTH: bank_bus.wr_data = {{PCD_PARAM_W{1'b0}}, CMD_WORD}; // [R09]
      PCD_SLOT_BIAS_LENGTH: bank_bus.wr_data = PCD_VAL_W'(CMD_WORD[PCD_BIAS_LEN_W-1:0]); // [R10]
      PCD_SLOT_OUT_MULT, PCD_SLOT_FIRST_MULT: bank_bus.wr_data = {10'h000, param_r[PCD_SHIFT_W-1:0], CMD_WORD}; // [R11] [R12]
      PCD_SLOT_SECOND_MULT: bank_bus.wr_data = {{PCD_PARAM_W{1'b0}}, CMD_WORD}; // [R13]
      default: bank_bus.wr_data = {param_r, CMD_WORD}; // [R05] [R06] [R07] [R08] [R14] [R15] [R16] [R17]
    endcase
    case (state_r)
      PCD_ST_HEADER: begin
        if (accept) begin
          if (word_class == PCD_CLASS_PAYLOAD) begin // [R01]
            op_nxt = word_op; // [R02]
            param_nxt = word_param;
            state_nxt = PCD_ST_PAYLOAD; // [R03]
          end else if (word_class == PCD_CLASS_PARAM) begin
            if (word_op == PCD_OP_COPY_SOURCE_REGION || word_op == PCD_OP_COPY_DESTINATION_REGION) begin
              stride_mode_nxt = word_param[PCD_STRIDE_MODE_LO +: 2]; // [R18]
            end
            if (word_op == PCD_OP_SET_COPY_ROW_COUNT) rows_nxt = word_param; // [R19]
            if (word_op == PCD_OP_INPUT_PRECISION_SETTING) prec32_nxt = (word_param[PCD_PREC_LO +: 2] == PCD_PREC_32BIT);
          end
        end
      end
      PCD_ST_PAYLOAD: begin
        if (accept) begin
          state_nxt = PCD_ST_HEADER; // [R03]
          done_cnt_nxt = done_cnt_r + 1'b1;
          if (slot_hit[PCD_SLOT_W]) bank_bus.wr_en = 1'b1;
          else unknown_cnt_nxt = unknown_cnt_r + 1'b1; // [R20]
        end
      end
      default: state_nxt = PCD_ST_HEADER;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_r <= PCD_ST_HEADER;
      op_r <= '0;
      param_r <= '0;
      stride_mode_r <= PCD_STRIDE_1D;
      prec32_r <= 1'b0;
      rows_r <= '0;
      done_cnt_r <= '0;
      unknown_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      param_r <= param_nxt;
      stride_mode_r <= stride_mode_nxt;
      prec32_r <= prec32_nxt;
      rows_r <= rows_nxt;
      done_cnt_r <= done_cnt_nxt;
      unknown_cnt_r <= unknown_cnt_nxt;
    end
  end

  // Address and data are taken together, so either arrival order works
  assign wr_hs = AWVALID && WVALID && !bvalid_r;
  assign AWREADY = wr_hs;
  assign WREADY = wr_hs;
  assign rd_hs = ARVALID && !rvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;

  // Effective multiplier registers reuse the single bank read port
  always_comb begin
    bank_bus.rd_idx = ARADDR[PCD_SLOT_W+2:3];
    case (ARADDR)
      PCD_REG_OPA_SHIFT, PCD_REG_OPA_SCALE: bank_bus.rd_idx = PCD_SLOT_FIRST_MULT;
      PCD_REG_OPB_SCALE: bank_bus.rd_idx = PCD_SLOT_SECOND_MULT;
      PCD_REG_OUT_SHIFT, PCD_REG_OUT_SCALE: bank_bus.rd_idx = PCD_SLOT_OUT_MULT;
      default: bank_bus.rd_idx = ARADDR[PCD_SLOT_W+2:3];
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    bvalid_nxt = bvalid_r && !BREADY;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !RREADY;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (wr_hs) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = PCD_RESP_SLVERR;
      if (AWADDR == PCD_REG_CTRL) begin
        bresp_nxt = PCD_RESP_OKAY;
        if (WSTRB[0]) ctrl_nxt = WDATA[2:0];
      end
    end
    if (rd_hs) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = PCD_RESP_OKAY;
      rdata_nxt = '0;
      case (ARADDR)
        PCD_REG_CTRL: rdata_nxt = PCD_WORD_W'(ctrl_r);
        PCD_REG_STATUS: rdata_nxt = {done_cnt_r, 12'h000, prec32_r, stride_mode_r, PAYLOAD_PENDING};
        PCD_REG_ROWS: rdata_nxt = PCD_WORD_W'(rows_r);
        PCD_REG_OPA_SHIFT: begin
          if (scale_mode != PCD_SCALE_MODE0) rdata_nxt = PCD_WORD_W'(bank_bus.rd_data[PCD_WORD_W +: PCD_SHIFT_W]); // [R12]
        end
        PCD_REG_OPA_SCALE: begin
          if (scale_mode == PCD_SCALE_MODE1) rdata_nxt = bank_bus.rd_data[PCD_WORD_W-1:0]; // [R12]
          else rdata_nxt = PCD_WORD_W'(bank_bus.rd_data[PCD_SCALE16_W-1:0]);
        end
        PCD_REG_OPB_SCALE: begin
          if (scale_mode == PCD_SCALE_MODE0) rdata_nxt = PCD_WORD_W'(bank_bus.rd_data[PCD_SCALE16_W-1:0]); // [R13]
        end
        PCD_REG_OUT_SHIFT: rdata_nxt = PCD_WORD_W'(bank_bus.rd_data[PCD_WORD_W +: PCD_SHIFT_W]); // [R11]
        PCD_REG_OUT_SCALE: begin
          if (!prec32_r) rdata_nxt = bank_bus.rd_data[PCD_WORD_W-1:0]; // [R11]
        end
        PCD_REG_UNKNOWN: rdata_nxt = PCD_WORD_W'(unknown_cnt_r);
        default: begin
          if (ARADDR[11:8] == PCD_SLOT_AREA && 32'(ARADDR[7:3]) < PCD_NUM_SLOTS) begin
            if (!ARADDR[2]) rdata_nxt = bank_bus.rd_data[PCD_WORD_W-1:0];
            else rdata_nxt = PCD_WORD_W'(bank_bus.rd_data[PCD_VAL_W-1:PCD_WORD_W]);
          end else begin
            rresp_nxt = PCD_RESP_SLVERR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl_r <= PCD_CTRL_RESET;
      bvalid_r <= 1'b0;
      bresp_r <= PCD_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= PCD_RESP_OKAY;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_class_detect: assert property ( // [R01]
    state_r == PCD_ST_HEADER && accept && word_class == PCD_CLASS_PAYLOAD |=> state_r == PCD_ST_PAYLOAD
  ) else $error("payload class not recognised");
  a_other_class_stays: assert property ( // [R01]
    state_r == PCD_ST_HEADER && accept && word_class != PCD_CLASS_PAYLOAD |=> state_r == PCD_ST_HEADER
  ) else $error("non-payload class entered payload wait");
  a_opcode_latch: assert property ( // [R02]
    state_r == PCD_ST_HEADER && accept |=> state_r == PCD_ST_PAYLOAD |-> op_r == $past(CMD_WORD[9:0])
  ) else $error("opcode not taken from bits 9:0");
  a_payload_consumed: assert property ( // [R03]
    state_r == PCD_ST_PAYLOAD && accept |=> state_r == PCD_ST_HEADER
  ) else $error("payload word not consumed");
  a_write_only_payload: assert property ( // [R03]
    bank_bus.wr_en |-> state_r == PCD_ST_PAYLOAD && accept
  ) else $error("bank written outside payload word");
  a_tile_slot: assert property ( // [R07]
    bank_bus.wr_en && op_r == 10'h013 |-> bank_bus.wr_idx == 5'h0a
  ) else $error("output tile 3 in wrong slot");
  a_stride_upper: assert property ( // [R06]
    bank_bus.wr_en && op_r == 10'h005 |-> bank_bus.wr_data[47:32] == param_r && bank_bus.wr_idx == 5'h05
  ) else $error("input stride upper bits wrong");
  a_coef_length: assert property ( // [R09]
    bank_bus.wr_en && op_r == 10'h021 |-> bank_bus.wr_data[47:32] == 16'h0000
  ) else $error("coefficient length upper bits not zero");
  a_bias_length: assert property ( // [R10]
    bank_bus.wr_en && op_r == 10'h023 |-> bank_bus.wr_data[47:20] == 28'h0000000
  ) else $error("bias length wider than 20 bits");
  a_out_shift: assert property ( // [R11]
    bank_bus.wr_en && op_r == 10'h024 |-> bank_bus.wr_data[47:38] == 10'h000
  ) else $error("output shift wider than 6 bits");
  a_stride_mode: assert property ( // [R18]
    state_r == PCD_ST_HEADER && accept && CMD_WORD[15:0] == 16'h0130 |=> stride_mode_r == $past(CMD_WORD[26:25])
  ) else $error("stride mode not taken from bits 10:9");
  a_row_count: assert property ( // [R19]
    state_r == PCD_ST_HEADER && accept && CMD_WORD[15:0] == 16'h0132 |=> rows_r == $past(CMD_WORD[31:16])
  ) else $error("row count not loaded");
  a_unlisted_none: assert property ( // [R20]
    state_r == PCD_ST_PAYLOAD && accept && op_r == 10'h007 |-> !bank_bus.wr_en ##1 state_r == PCD_ST_HEADER
  ) else $error("unlisted opcode wrote a parameter");
  a_write_answer: assert property (
    wr_hs |=> BVALID && BRESP == $past(AWADDR == PCD_REG_CTRL ? PCD_RESP_OKAY : PCD_RESP_SLVERR)
  ) else $error("write response missing");
endmodule

// ==== hdl/pcd_pkg.sv ====
package pcd_pkg;
  localparam int unsigned PCD_WORD_W = 32;
  localparam int unsigned PCD_PARAM_W = 16;
  localparam int unsigned PCD_VAL_W = 48;
  localparam int unsigned PCD_OP_W = 10;
  localparam int unsigned PCD_SLOT_W = 5;
  localparam int unsigned PCD_NUM_SLOTS = 26;
  localparam int unsigned PCD_ADDR_W = 12;
  localparam int unsigned PCD_CNT_W = 16;

  // Command word layout
  localparam int unsigned PCD_CLASS_HI = 15;
  localparam int unsigned PCD_CLASS_LO = 14;
  localparam int unsigned PCD_OP_LO = 0;
  localparam int unsigned PCD_PARAM_LO = 16;
  localparam logic [1:0] PCD_CLASS_PARAM = 2'h0;
  localparam logic [1:0] PCD_CLASS_PAYLOAD = 2'h1;

  // Parameter-only commands that this block snoops
  localparam logic [9:0] PCD_OP_COPY_SOURCE_REGION = 10'h130;
  localparam logic [9:0] PCD_OP_COPY_DESTINATION_REGION = 10'h131;
  localparam logic [9:0] PCD_OP_SET_COPY_ROW_COUNT = 10'h132;
  localparam logic [9:0] PCD_OP_INPUT_PRECISION_SETTING = 10'h185;
  localparam int unsigned PCD_STRIDE_MODE_LO = 9;
  localparam int unsigned PCD_PREC_LO = 2;
  localparam logic [1:0] PCD_PREC_32BIT = 2'h2;
  localparam logic [1:0] PCD_STRIDE_1D = 2'h0;

  // Payload command groups: first opcode, first slot, member count
  localparam logic [9:0] PCD_OP_INPUT_GROUP = 10'h000;
  localparam logic [9:0] PCD_OP_OUTPUT_GROUP = 10'h010;
  localparam logic [9:0] PCD_OP_STREAM_GROUP = 10'h020;
  localparam logic [9:0] PCD_OP_COPY_GROUP = 10'h030;
  localparam logic [9:0] PCD_GROUP_MASK = 10'h3f0;
  localparam logic [3:0] PCD_MAP_GROUP_LEN = 4'h7;
  localparam logic [3:0] PCD_COPY_GROUP_LEN = 4'h5;
  localparam logic [4:0] PCD_SLOT_INPUT = 5'h00;
  localparam logic [4:0] PCD_SLOT_INPUT_STRIDE = 5'h04;
  localparam logic [4:0] PCD_SLOT_OUTPUT = 5'h07;
  localparam logic [4:0] PCD_SLOT_OUTPUT_STRIDE = 5'h0b;
  localparam logic [4:0] PCD_SLOT_COEF_OFFSET = 5'h0e;
  localparam logic [4:0] PCD_SLOT_COEF_LENGTH = 5'h0f;
  localparam logic [4:0] PCD_SLOT_BIAS_LENGTH = 5'h11;
  localparam logic [4:0] PCD_SLOT_OUT_MULT = 5'h12;
  localparam logic [4:0] PCD_SLOT_FIRST_MULT = 5'h13;
  localparam logic [4:0] PCD_SLOT_SECOND_MULT = 5'h14;
  localparam logic [4:0] PCD_SLOT_COPY = 5'h15;
  localparam int unsigned PCD_SHIFT_W = 6;
  localparam int unsigned PCD_SCALE16_W = 16;
  localparam int unsigned PCD_BIAS_LEN_W = 20;

  // Register map, byte addresses
  localparam logic [11:0] PCD_REG_CTRL = 12'h000;
  localparam logic [11:0] PCD_REG_STATUS = 12'h004;
  localparam logic [11:0] PCD_REG_ROWS = 12'h008;
  localparam logic [11:0] PCD_REG_OPA_SHIFT = 12'h00c;
  localparam logic [11:0] PCD_REG_OPA_SCALE = 12'h010;
  localparam logic [11:0] PCD_REG_OPB_SCALE = 12'h014;
  localparam logic [11:0] PCD_REG_OUT_SHIFT = 12'h018;
  localparam logic [11:0] PCD_REG_OUT_SCALE = 12'h01c;
  localparam logic [11:0] PCD_REG_UNKNOWN = 12'h020;
  localparam logic [3:0] PCD_SLOT_AREA = 4'h1;
  localparam int unsigned PCD_CTRL_EN_BIT = 0;
  localparam int unsigned PCD_CTRL_MODE_LO = 1;
  localparam logic [2:0] PCD_CTRL_RESET = 3'h1;
  localparam logic [1:0] PCD_SCALE_MODE0 = 2'h0;
  localparam logic [1:0] PCD_SCALE_MODE1 = 2'h1;
  localparam logic [1:0] PCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCD_RESP_SLVERR = 2'h2;

  typedef enum logic {PCD_ST_HEADER, PCD_ST_PAYLOAD} pcd_state_type;

  // Returns {hit, slot} for a payload-carrying opcode
  function automatic logic [5:0] pcd_slot_of(input logic [9:0] op);
    logic [3:0] low;
    low = op[3:0];
    pcd_slot_of = 6'h00;
    case (op & PCD_GROUP_MASK)
      PCD_OP_INPUT_GROUP: if (low < PCD_MAP_GROUP_LEN) pcd_slot_of = {1'b1, PCD_SLOT_INPUT + {1'b0, low}};
      PCD_OP_OUTPUT_GROUP: if (low < PCD_MAP_GROUP_LEN) pcd_slot_of = {1'b1, PCD_SLOT_OUTPUT + {1'b0, low}};
      PCD_OP_STREAM_GROUP: if (low < PCD_MAP_GROUP_LEN) pcd_slot_of = {1'b1, PCD_SLOT_COEF_OFFSET + {1'b0, low}};
      PCD_OP_COPY_GROUP: if (low < PCD_COPY_GROUP_LEN) pcd_slot_of = {1'b1, PCD_SLOT_COPY + {1'b0, low}};
      default: pcd_slot_of = 6'h00;
    endcase
  endfunction
endpackage

// ==== tb/pcd_cmd_source.sv ====
`timescale 1ns/10ps
module pcd_cmd_source import pcd_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [PCD_WORD_W-1:0] cmd_word
);
  logic [PCD_WORD_W-1:0] q[$];
  int gap = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_word = '0;
  end
  task automatic push(input logic [PCD_WORD_W-1:0] w);
    q.push_back(w);
  endtask
  // A word leaves the queue only when taken, so a header is always followed by its payload
  always @(posedge clk) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      gap = 0;
    end else if (!cmd_valid || cmd_ready) begin
      if (cmd_valid) begin
        void'(q.pop_front());
        gap = slow ? 2 : 0;
      end
      if (q.size() > 0 && gap == 0) begin
        cmd_valid <= 1'b1;
        cmd_word <= q[0];
      end else begin
        // Idle data lines toggle so nothing can lean on a stale word
        cmd_valid <= 1'b0;
        cmd_word <= ~cmd_word;
        if (gap > 0) gap = gap - 1;
      end
    end
  end
endmodule

// ==== tb/pcd_payload_command_decoder_test.sv ====
`timescale 1ns/10ps
module pcd_payload_command_decoder_test import pcd_pkg::*; ;
  typedef struct {
    logic [9:0] op;
    logic [15:0] param;
    logic [31:0] pay;
    logic [31:0] lo;
    logic [31:0] hi;
  } pcd_row_type;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic slow = 1'b0;
  logic CMD_VALID, CMD_READY, PAYLOAD_PENDING;
  logic [31:0] CMD_WORD;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hf;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [2:0] prot = 3'h0;
  int errors = 0;
  int checked = 0;
  pcd_row_type rows[26];
  logic [9:0] bad[6] = '{10'h007, 10'h00f, 10'h017, 10'h027, 10'h035, 10'h03f};
  logic [31:0] d;
  logic [1:0] r;

  pcd_payload_command_decoder u_dut (
    .CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_WORD(CMD_WORD),
    .PAYLOAD_PENDING(PAYLOAD_PENDING), .AWADDR(AWADDR), .AWPROT(prot), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(prot), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );
  pcd_cmd_source u_src (.clk(CLK), .rst_b(RST_B), .slow(slow), .cmd_ready(CMD_READY), .cmd_valid(CMD_VALID),
    .cmd_word(CMD_WORD));

  initial begin
    forever #10 CLK = ~CLK;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    errors++;
    $display("ERROR at %0t: no answer, got %h expected %h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask

  // Handshakes are sampled at the falling edge, where they equal what the next rising edge sees
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rr);
    int n;
    logic aw, w, b;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge CLK);
      aw = AWVALID && AWREADY === 1'b1;
      w = WVALID && WREADY === 1'b1;
      b = BVALID === 1'b1;
      rr = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) break;
    end
    if (n == 50) timed_out();
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    int n;
    logic ar, rv;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge CLK);
      ar = ARVALID && ARREADY === 1'b1;
      rv = RVALID === 1'b1;
      v = RDATA;
      rr = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
      if (rv) break;
    end
    if (n == 50) timed_out();
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    axi_rd(a, v, rr);
    chk(v, e);
  endtask

  task automatic settle();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge CLK);
      if (u_src.q.size() == 0 && CMD_VALID === 1'b0) break;
    end
    if (n == 100) timed_out();
    @(posedge CLK);
  endtask

  task automatic send_cmd(input logic [9:0] op, input logic [15:0] prm, input logic [31:0] pay);
    u_src.push({prm, 6'h10, op});
    u_src.push(pay);
    settle();
  endtask

  initial begin
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd_chk(PCD_REG_CTRL, 32'h1);
    rd_chk(PCD_REG_STATUS, 32'h0);
    rd_chk(PCD_REG_ROWS, 32'h0);
    for (int i = 0; i < 26; i++) begin
      rows[i].op = (i < 7) ? 10'(i) : (i < 14) ? 10'(i + 9) : (i < 21) ? 10'(i + 18) : 10'(i + 27);
      rows[i].param = (i == 15 || i == 17) ? 16'h0 : 16'hc000 + 16'(i);
      rows[i].pay = 32'hf1e2_0000 + 32'(i) * 32'h111;
      rows[i].lo = (i == 17) ? rows[i].pay & 32'h000f_ffff : rows[i].pay;
      rows[i].hi = (i == 18 || i == 19) ? {26'h0, rows[i].param[5:0]} : (i == 20) ? 32'h0 : {16'h0, rows[i].param};
    end
    for (int i = 0; i < 26; i++) begin
      slow <= i[0];
      send_cmd(rows[i].op, rows[i].param, rows[i].pay);
      rd_chk(12'h100 + 12'(i * 8), rows[i].lo);
      rd_chk(12'h104 + 12'(i * 8), rows[i].hi);
    end
    // Payloads that look like headers must not be decoded as one
    for (int k = 0; k < 6; k++) begin
      send_cmd(bad[k], 16'h0, 32'h0000_4010);
    end
    rd_chk(PCD_REG_UNKNOWN, 32'h6);
    u_src.push(32'h0000_8010);
    settle();
    rd_chk(12'h138, rows[7].lo);
    send_cmd(10'h010, 16'h0, 32'h0bad_cafe);
    rd_chk(12'h138, 32'h0bad_cafe);
    for (int m = 0; m < 3; m++) begin
      u_src.push({5'h0, 2'(m), 9'h000, 16'h0130 + 16'(m % 2)});
      settle();
      axi_rd(PCD_REG_STATUS, d, r);
      chk({30'h0, d[2:1]}, 32'(m));
      chk(d, {16'h0021, 13'h0000, 2'(m), 1'b0});
    end
    u_src.push({16'hffff, 16'h0132});
    settle();
    rd_chk(PCD_REG_ROWS, 32'h0000_ffff);
    send_cmd(10'h025, 16'h002b, 32'habcd_1234);
    send_cmd(10'h026, 16'h0, 32'h5555_aaaa);
    for (int m = 0; m < 3; m++) begin
      axi_wr(PCD_REG_CTRL, {29'h0, 2'(m), 1'b1}, r);
      chk({30'h0, r}, {30'h0, PCD_RESP_OKAY});
      rd_chk(PCD_REG_OPA_SHIFT, (m == 0) ? 32'h0 : 32'h2b);
      rd_chk(PCD_REG_OPA_SCALE, (m == 1) ? 32'habcd_1234 : 32'h1234);
      rd_chk(PCD_REG_OPB_SCALE, (m == 0) ? 32'haaaa : 32'h0);
    end
    send_cmd(10'h024, 16'h002a, 32'h8765_4321);
    rd_chk(PCD_REG_OUT_SCALE, 32'h8765_4321);
    u_src.push({16'h0008, 16'h0185});
    settle();
    rd_chk(PCD_REG_OUT_SCALE, 32'h0);
    rd_chk(PCD_REG_OUT_SHIFT, 32'h2a);
    // Stream stalled while disabled, then a header waits for its payload
    axi_wr(PCD_REG_CTRL, 32'h0, r);
    u_src.push({16'h0001, 16'h4000});
    repeat (5) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, CMD_READY}, 32'h0);
    chk({30'h0, CMD_VALID, PAYLOAD_PENDING}, 32'h2);
    @(posedge CLK);
    axi_wr(PCD_REG_CTRL, 32'h1, r);
    settle();
    @(negedge CLK);
    chk({31'h0, PAYLOAD_PENDING}, 32'h1);
    @(posedge CLK);
    rd_chk(12'h100, rows[0].lo);
    u_src.push(32'h0000_0777);
    settle();
    rd_chk(12'h100, 32'h777);
    rd_chk(12'h104, 32'h1);
    // Byte 0 strobe clear must leave the control field alone
    WSTRB <= 4'he;
    axi_wr(PCD_REG_CTRL, 32'h0, r);
    WSTRB <= 4'hf;
    rd_chk(PCD_REG_CTRL, 32'h1);
    axi_rd(12'h0f0, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, PCD_RESP_SLVERR});
    axi_wr(PCD_REG_STATUS, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, PCD_RESP_SLVERR});
    RST_B <= 1'b0;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd_chk(12'h138, 32'h0);
    rd_chk(PCD_REG_UNKNOWN, 32'h0);
    rd_chk(PCD_REG_STATUS, 32'h0);
    rd_chk(PCD_REG_ROWS, 32'h0);
    rd_chk(PCD_REG_CTRL, 32'h1);
    wrap_up();
  end
endmodule
